// >>> src/pmlp_pkg.sv
package pmlp_pkg;
	// ==========================================
	// Timing
	localparam int unsigned PMLP_CLK_NS = 8;
	localparam int unsigned PMLP_BLINK_HALF_NS = 50_000_000;
	localparam int unsigned PMLP_BLINK_HALF_CYC = PMLP_BLINK_HALF_NS / PMLP_CLK_NS;
	localparam int unsigned PMLP_ACT_HOLD_NS = 100_000_000;
	localparam int unsigned PMLP_ACT_HOLD_CYC = PMLP_ACT_HOLD_NS / PMLP_CLK_NS;
	localparam int PMLP_TMR_W = 24;

	// ==========================================
	// Register indices, byte address = 4 * index
	localparam int PMLP_ADDR_W = 8;
	localparam logic [5:0] PMLP_IDX_BASIC = 6'h00;
	localparam logic [5:0] PMLP_IDX_ADVERT = 6'h04;
	localparam logic [5:0] PMLP_IDX_LIGHT = 6'h1F;
	localparam logic [5:0] PMLP_IDX_LINK = 6'h20;
	localparam logic [5:0] PMLP_IDX_STAT = 6'h21;

	// ==========================================
	// Field positions
	localparam int PMLP_BASIC_SPEED_BIT = 13;
	localparam int PMLP_ADV_100_LO = 7;
	localparam int PMLP_ADV_10_LO = 5;
	localparam int PMLP_LIGHT_MODE_LO = 4;
	localparam int PMLP_LINK_RMII_BIT = 0;
	localparam int PMLP_STAT_STRAP_BIT = 0;
	localparam int PMLP_STAT_ACT_BIT = 1;
	localparam int PMLP_STAT_PIN_BIT = 2;

	// ==========================================
	// Codes and reset values
	localparam logic [1:0] PMLP_MODE_SPEED = 2'h0;
	localparam logic [1:0] PMLP_MODE_ACT = 2'h1;
	localparam logic [1:0] PMLP_LIGHT_MODE_RST = 2'h0;
	localparam logic [1:0] PMLP_ADV_10_RST = 2'h3;
	localparam logic PMLP_RMII_RST = 1'h0;
	localparam logic [1:0] PMLP_RESP_OKAY = 2'h0;
	localparam logic [1:0] PMLP_RESP_SLVERR = 2'h2;

	// One transfer unit on a data path
	typedef struct packed {
		logic en;
		logic [3:0] data;
	} pmlp_unit_type;
endpackage

// >>> src/pmlp_top.sv
`timescale 1ns/10ps

// Summary of operation
// RULE_01 - Two-bit light mode: 00 speed, 01 activity, 10 and 11 reserved.
// RULE_02 - Speed mode: light pin high at 10 Mbps, low at 100 Mbps.
// RULE_03 - Activity mode: pin high when idle, toggling while activity lasts.
// RULE_04 - Light pin level around reset is loaded as the speed select bit.
// RULE_05 - Whole block held in reset while the chip reset input is low.
// RULE_06 - Strap pin is an input during reset and an output afterwards.
// RULE_07 - RMII receive data is driven synchronous to the reference clock.
// RULE_08 - Each RMII clock with carrier/data valid delivers two received bits.
// RULE_09 - MAC drives RMII transmit data synchronous to the reference clock.
// RULE_10 - Each RMII clock with transmit enable accepts two transmit bits.
// RULE_11 - MAC drives MII transmit nibbles synchronous to the transmit clock.
// RULE_12 - Transmit data lines are ignored while transmit enable is low.
// RULE_13 - Strap high selects 100 Mbps, strap low selects 10 Mbps.
// RULE_14 - Strapped speed also sets the advertised 100 Mbps capability.
// RULE_15 - Blink rate is fixed and visible; blinking stops when activity ends.
module pmlp_top
	import pmlp_pkg::*;
#(
	parameter int unsigned BLINK_HALF_CYC = PMLP_BLINK_HALF_CYC,
	parameter int unsigned ACT_HOLD_CYC = PMLP_ACT_HOLD_CYC
)
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CHIP_RESET_N,
	input wire logic LINK_CLK,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [PMLP_ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	output logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	input wire logic [PMLP_ADDR_W-1:0] S_AXI_ARADDR,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	input wire logic TXEN,
	input wire logic [3:0] TXD,
	output logic [1:0] RXD,
	output logic CRS_DV,
	input wire pmlp_unit_type LINE_RX,
	output pmlp_unit_type LINE_TX,
	input wire logic STATUS_LIGHT_IN,
	output logic STATUS_LIGHT_OUT,
	output logic STATUS_LIGHT_OE_N
);

	// ==========================================
	// Reset and pin synchronisers

	localparam logic [PMLP_TMR_W-1:0] half_last = PMLP_TMR_W'(BLINK_HALF_CYC - 1);
	localparam logic [PMLP_TMR_W-1:0] hold_load = PMLP_TMR_W'(ACT_HOLD_CYC);

	logic crn_s1;
	logic crn_s2;
	logic li_s1;
	logic li_s2;
	logic rst_sys;

	// Chip reset pin and strap pin come from outside
	always_ff @(posedge CLOCK)
	begin
		crn_s1 <= CHIP_RESET_N;
		crn_s2 <= crn_s1;
		li_s1 <= STATUS_LIGHT_IN;
		li_s2 <= li_s1;
	end

	// Either reset source holds everything
	assign rst_sys = RST | ~crn_s2; // [RULE_05]

	// ==========================================
	// Register bus slave

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic [5:0] aw_idx_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_wr;
	logic wr_hit;
	logic [5:0] ar_idx;
	logic rd_hit;
	logic [31:0] rd_word;
	logic [31:0] basic_old;
	logic [31:0] basic_wr;

	logic speed_q;
	logic [1:0] adv100_q;
	logic [1:0] adv10_q;
	logic [1:0] mode_q;
	logic rmii_q;
	logic act_on;
	logic light_q;

	// Byte lanes merge new data over the old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
			begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address and data taken in either order, held until the response
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			aw_idx_q <= 6'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end
		else if (bvalid_q && S_AXI_BREADY)
		begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
		end
		else
		begin
			if (awready_q && S_AXI_AWVALID)
			begin
				awready_q <= 1'b0;
				aw_idx_q <= S_AXI_AWADDR[PMLP_ADDR_W-1:2];
			end
			if (wready_q && S_AXI_WVALID)
			begin
				wready_q <= 1'b0;
				wdata_q <= S_AXI_WDATA;
				wstrb_q <= S_AXI_WSTRB;
			end
		end
	end

	assign do_wr = !awready_q && !wready_q && !bvalid_q;
	assign wr_hit = aw_idx_q == PMLP_IDX_BASIC || aw_idx_q == PMLP_IDX_ADVERT
		|| aw_idx_q == PMLP_IDX_LIGHT || aw_idx_q == PMLP_IDX_LINK;

	// Write response one cycle after both halves are held
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= PMLP_RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? PMLP_RESP_OKAY : PMLP_RESP_SLVERR;
		end
		else if (bvalid_q && S_AXI_BREADY)
		begin
			bvalid_q <= 1'b0;
		end
	end

	assign ar_idx = S_AXI_ARADDR[PMLP_ADDR_W-1:2];

	// Read mux; unmapped words read as zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (ar_idx)
			PMLP_IDX_BASIC: rd_word[PMLP_BASIC_SPEED_BIT] = speed_q;
			PMLP_IDX_ADVERT:
			begin
				rd_word[PMLP_ADV_100_LO +: 2] = adv100_q;
				rd_word[PMLP_ADV_10_LO +: 2] = adv10_q;
			end
			PMLP_IDX_LIGHT: rd_word[PMLP_LIGHT_MODE_LO +: 2] = mode_q;
			PMLP_IDX_LINK: rd_word[PMLP_LINK_RMII_BIT] = rmii_q;
			PMLP_IDX_STAT:
			begin
				rd_word[PMLP_STAT_STRAP_BIT] = li_s2;
				rd_word[PMLP_STAT_ACT_BIT] = act_on;
				rd_word[PMLP_STAT_PIN_BIT] = light_q;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= PMLP_RESP_OKAY;
		end
		else if (arready_q && S_AXI_ARVALID)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= rd_hit ? PMLP_RESP_OKAY : PMLP_RESP_SLVERR;
		end
		else if (rvalid_q && S_AXI_RREADY)
		begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// ==========================================
	// Control registers

	// Current word with lanes overlaid; a lane not strobed keeps its bits
	always_comb
	begin
		basic_old = 32'h0000_0000;
		basic_old[PMLP_BASIC_SPEED_BIT] = speed_q;
		basic_wr = merge(basic_old, wdata_q, wstrb_q);
	end

	// Speed select; strap level reloads it for as long as reset lasts
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			speed_q <= li_s2; // [RULE_04] [RULE_13]
		end
		else if (do_wr && aw_idx_q == PMLP_IDX_BASIC)
		begin
			speed_q <= basic_wr[PMLP_BASIC_SPEED_BIT];
		end
	end

	// Advertised abilities; 100 Mbps ones follow the strap
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			adv100_q <= {2{li_s2}}; // [RULE_14]
			adv10_q <= PMLP_ADV_10_RST;
		end
		else if (do_wr && aw_idx_q == PMLP_IDX_ADVERT && wstrb_q[0])
		begin
			adv10_q <= wdata_q[PMLP_ADV_10_LO +: 2];
			adv100_q[0] <= wdata_q[PMLP_ADV_100_LO];
		end
		if (!rst_sys && do_wr && aw_idx_q == PMLP_IDX_ADVERT && wstrb_q[1])
		begin
			adv100_q[1] <= wdata_q[PMLP_ADV_100_LO + 1];
		end
	end

	// Light mode and interface mode
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			mode_q <= PMLP_LIGHT_MODE_RST;
			rmii_q <= PMLP_RMII_RST;
		end
		else if (do_wr && wstrb_q[0])
		begin
			if (aw_idx_q == PMLP_IDX_LIGHT)
			begin
				mode_q <= wdata_q[PMLP_LIGHT_MODE_LO +: 2]; // [RULE_01]
			end
			if (aw_idx_q == PMLP_IDX_LINK)
			begin
				rmii_q <= wdata_q[PMLP_LINK_RMII_BIT];
			end
		end
	end

	// ==========================================
	// Link clock domain

	logic rst_link_q;
	logic lrst_s1;
	logic lrst_s2;
	logic lrmii_s1;
	logic lrmii_s2;
	pmlp_unit_type line_tx_q;
	logic [1:0] rxd_q;
	logic crs_dv_q;
	logic act_tgl_q;

	// Registered copy, so a glitch of the reset OR never reaches the other domain
	always_ff @(posedge CLOCK)
	begin
		rst_link_q <= rst_sys;
	end

	// Reset and mode levels cross into the link domain
	always_ff @(posedge LINK_CLK)
	begin
		lrst_s1 <= rst_link_q;
		lrst_s2 <= lrst_s1;
		lrmii_s1 <= rmii_q;
		lrmii_s2 <= lrmii_s1;
	end

	// MAC data sampled on the link clock it was launched from
	always_ff @(posedge LINK_CLK)
	begin
		if (lrst_s2)
		begin
			line_tx_q <= '0;
		end
		else
		begin
			line_tx_q.en <= TXEN; // [RULE_09] [RULE_11]
			if (!TXEN)
			begin
				line_tx_q.data <= 4'h0; // [RULE_12]
			end
			else if (lrmii_s2)
			begin
				line_tx_q.data <= {2'h0, TXD[1:0]}; // [RULE_10]
			end
			else
			begin
				line_tx_q.data <= TXD;
			end
		end
	end

	// Two recovered bits per reference clock while valid
	always_ff @(posedge LINK_CLK)
	begin
		if (lrst_s2 || !lrmii_s2)
		begin
			crs_dv_q <= 1'b0;
			rxd_q <= 2'h0;
		end
		else
		begin
			crs_dv_q <= LINE_RX.en; // [RULE_07]
			rxd_q <= LINE_RX.en ? LINE_RX.data[1:0] : 2'h0; // [RULE_08]
		end
	end

	// Activity is sent across as a toggle, one flip per busy link cycle
	always_ff @(posedge LINK_CLK)
	begin
		if (lrst_s2)
		begin
			act_tgl_q <= 1'b0;
		end
		else if (TXEN || (lrmii_s2 && LINE_RX.en))
		begin
			act_tgl_q <= ~act_tgl_q;
		end
	end

	// ==========================================
	// Status light

	logic at_s1;
	logic at_s2;
	logic at_s3;
	logic act_pulse;
	logic [PMLP_TMR_W-1:0] hold_q;
	logic [PMLP_TMR_W-1:0] blink_cnt_q;
	logic blink_q;
	logic oe_n_q;

	// Third stage only feeds the edge detector
	always_ff @(posedge CLOCK)
	begin
		at_s1 <= act_tgl_q;
		at_s2 <= at_s1;
		at_s3 <= at_s2;
	end

	assign act_pulse = at_s2 ^ at_s3;
	assign act_on = hold_q != '0;

	// Retrigger keeps blinking through bursts, expiry ends it
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			hold_q <= '0;
		end
		else if (act_pulse)
		begin
			hold_q <= hold_load;
		end
		else if (act_on)
		begin
			hold_q <= hold_q - 1'b1; // [RULE_15]
		end
	end

	// Fixed visible blink period, phase restarts at idle
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys || !act_on)
		begin
			blink_cnt_q <= '0;
			blink_q <= 1'b0;
		end
		else if (blink_cnt_q == half_last)
		begin
			blink_cnt_q <= '0;
			blink_q <= ~blink_q; // [RULE_15]
		end
		else
		begin
			blink_cnt_q <= blink_cnt_q + 1'b1;
		end
	end

	// Pin released during reset so the strap pull can be read
	always_ff @(posedge CLOCK)
	begin
		if (rst_sys)
		begin
			oe_n_q <= 1'b1; // [RULE_06]
			light_q <= 1'b1;
		end
		else
		begin
			oe_n_q <= 1'b0; // [RULE_06]
			case (mode_q)
				PMLP_MODE_SPEED: light_q <= ~speed_q; // [RULE_02]
				PMLP_MODE_ACT: light_q <= act_on ? blink_q : 1'b1; // [RULE_03]
				default: light_q <= 1'b1; // [RULE_01]
			endcase
		end
	end

	// ==========================================
	// Outputs

	assign S_AXI_AWREADY = awready_q;
	assign S_AXI_WREADY = wready_q;
	assign S_AXI_BVALID = bvalid_q;
	assign S_AXI_BRESP = bresp_q;
	assign S_AXI_ARREADY = arready_q;
	assign S_AXI_RVALID = rvalid_q;
	assign S_AXI_RDATA = rdata_q;
	assign S_AXI_RRESP = rresp_q;
	assign RXD = rxd_q;
	assign CRS_DV = crs_dv_q;
	assign LINE_TX = line_tx_q;
	assign STATUS_LIGHT_OUT = light_q;
	assign STATUS_LIGHT_OE_N = oe_n_q;

endmodule // pmlp_top

// >>> tb/pmlp_mac_model.sv
`timescale 1ns/10ps
module pmlp_mac_model
	import pmlp_pkg::*;
#(
	parameter int LEN = 8
)
(
	input wire logic link_clk,
	input wire logic go,
	output logic txen,
	output logic [3:0] txd,
	output pmlp_unit_type line_rx
);
	logic seen_q = 1'b0;
	logic [7:0] left_q = 8'h00;
	logic [3:0] pat_q = 4'h0;
	// ======
	// Frame of LEN units per go toggle; data moves every cycle so stale values never pass
	always_ff @(posedge link_clk)
	begin
		seen_q <= go;
		pat_q <= pat_q + 4'h7;
		if (go != seen_q)
			left_q <= 8'(LEN);
		else if (left_q != 8'h00)
			left_q <= left_q - 8'h01;
	end
	// Line side mirrors the frame with other bits
	assign txen = left_q != 8'h00;
	assign txd = pat_q;
	assign line_rx = '{en: txen, data: ~pat_q};
endmodule // pmlp_mac_model

// >>> tb/pmlp_props.sv
`timescale 1ns/10ps
module pmlp_props
	import pmlp_pkg::*;
(
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CHIP_RESET_N,
	input wire logic LINK_CLK,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic TXEN,
	input wire logic [3:0] TXD,
	input wire pmlp_unit_type LINE_TX,
	input wire pmlp_unit_type LINE_RX,
	input wire logic [1:0] RXD,
	input wire logic CRS_DV,
	input wire logic STATUS_LIGHT_OUT,
	input wire logic STATUS_LIGHT_OE_N
);
	// ======
	// Either reset source quiets the link checks
	wire link_off = RST || !CHIP_RESET_N;

	// Light pin dark and released while either reset holds
	chk_reset_dark: assert property (@(posedge CLOCK)
		RST |=> STATUS_LIGHT_OE_N && STATUS_LIGHT_OUT)
		else $error("light not idle in reset");
	chk_chip_dark: assert property (@(posedge CLOCK) disable iff (RST)
		!CHIP_RESET_N [*4] |-> STATUS_LIGHT_OE_N && STATUS_LIGHT_OUT)
		else $error("chip reset ignored");
	// Sync delay of the chip reset bounds the turn to output
	chk_strap_drive: assert property (@(posedge CLOCK) disable iff (RST)
		$rose(CHIP_RESET_N) |-> ##[1:6] !STATUS_LIGHT_OE_N)
		else $error("light pin never driven");
	chk_read_answer: assert property (@(posedge CLOCK) disable iff (RST)
		S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	// ======
	// Link side, one link clock of latency
	chk_tx_enable: assert property (@(posedge LINK_CLK) disable iff (link_off)
		LINE_TX.en == $past(TXEN))
		else $error("tx enable not carried");
	chk_tx_data: assert property (@(posedge LINK_CLK) disable iff (link_off)
		$past(TXEN) |-> LINE_TX.data[1:0] == $past(TXD[1:0]))
		else $error("tx bits lost");
	chk_tx_ignored: assert property (@(posedge LINK_CLK) disable iff (link_off)
		!$past(TXEN) |-> LINE_TX.data == 4'h0)
		else $error("tx data used while idle");
	chk_rx_valid: assert property (@(posedge LINK_CLK) disable iff (link_off)
		CRS_DV |-> $past(LINE_RX.en) && RXD == $past(LINE_RX.data[1:0]))
		else $error("rx pair wrong");
	chk_rx_quiet: assert property (@(posedge LINK_CLK) disable iff (link_off)
		!CRS_DV |-> RXD == 2'h0)
		else $error("rx data without valid");
endmodule // pmlp_props

bind pmlp_top pmlp_props chk (.CLOCK(CLOCK), .RST(RST), .CHIP_RESET_N(CHIP_RESET_N),
	.LINK_CLK(LINK_CLK), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID), .TXEN(TXEN), .TXD(TXD), .LINE_TX(LINE_TX),
	.LINE_RX(LINE_RX), .RXD(RXD), .CRS_DV(CRS_DV), .STATUS_LIGHT_OUT(STATUS_LIGHT_OUT),
	.STATUS_LIGHT_OE_N(STATUS_LIGHT_OE_N));

// >>> tb/pmlp_top_bench.sv
`timescale 1ns/10ps
module pmlp_top_bench
	import pmlp_pkg::*;
;
	logic clk = 0, rst = 1, chip_n = 0, lclk = 0, pull = 1, go = 0, mon_on = 0, rmii = 0;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, lp;
	logic [7:0] aa = 0, ra = 0;
	logic [31:0] wd = 0, rdat, rdata;
	logic [1:0] rsp, bresp, rresp, rxd;
	logic awr, wr_rdy, bv, arr, rv, txen, oe_n, lout, crs;
	logic [3:0] txd;
	logic [2:0] p_rx = 0;
	pmlp_unit_type line_rx, line_tx, p_tx = 0;
	int n_mismatch = 0, num_checks = 0, k, t;
	wire pin = oe_n ? pull : lout;
	// Rows: write, address, data, expected read, expected response
	localparam logic [74:0] TBL [8] = '{
		{1'b0, 8'h00, 32'h0, 32'h0000_2000, 2'h0},
		{1'b0, 8'h10, 32'h0, 32'h0000_01E0, 2'h0},
		{1'b0, 8'h7C, 32'h0, 32'h0, 2'h0},
		{1'b1, 8'h7C, 32'h0000_0010, 32'h0, 2'h0},
		{1'b0, 8'h7C, 32'h0, 32'h0000_0010, 2'h0},
		{1'b1, 8'h84, 32'h0000_0007, 32'h0, 2'h2},
		{1'b0, 8'h08, 32'h0, 32'h0, 2'h2},
		{1'b1, 8'h7C, 32'h0, 32'h0, 2'h0}};

	pmlp_top #(.BLINK_HALF_CYC(4), .ACT_HOLD_CYC(40)) DUT (.CLOCK(clk), .RST(rst),
		.CHIP_RESET_N(chip_n), .LINK_CLK(lclk), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_AWADDR(aa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp),
		.S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ra), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(rr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .TXEN(txen), .TXD(txd),
		.RXD(rxd), .CRS_DV(crs), .LINE_RX(line_rx), .LINE_TX(line_tx),
		.STATUS_LIGHT_IN(pin), .STATUS_LIGHT_OUT(lout), .STATUS_LIGHT_OE_N(oe_n));
	pmlp_mac_model mac (.link_clk(lclk), .go(go), .txen(txen), .txd(txd), .line_rx(line_rx));

	// ======
	// Clocks; link phase offset keeps edges apart
	initial forever #4 clk = ~clk;
	initial
	begin
		#3;
		forever #80 lclk = ~lclk;
	end
	initial
	begin
		#100_000;
		n_mismatch++;
		wrap_up();
	end

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp1(input string nm, input logic e, input logic g);
		cmp(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One bus cycle; each channel released at its own handshake
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awv <= w;
		wv <= w;
		br <= w;
		arv <= !w;
		rr <= !w;
		aa <= a;
		ra <= a;
		wd <= d;
		forever
		begin
			@(posedge clk);
			if (awv && awr) awv <= 0;
			if (wv && wr_rdy) wv <= 0;
			if (arv && arr) arv <= 0;
			if (br && bv)
			begin
				rsp = bresp;
				br <= 0;
				break;
			end
			if (rr && rv)
			begin
				rdat = rdata;
				rsp = rresp;
				rr <= 0;
				break;
			end
		end
	endtask
	// Counts light changes over n cycles into t
	task automatic count_flips(input int n);
		t = 0;
		lp = lout;
		repeat (n)
		begin
			@(posedge clk);
			if (lout !== lp) t++;
			lp = lout;
		end
	endtask

	// Link monitor, expected units built from what the MAC drove
	always @(posedge lclk)
	begin
		if (mon_on)
		begin
			cmp("tx_unit", 32'(p_tx), 32'(line_tx));
			cmp("rx_pair", 32'(p_rx), 32'({crs, rxd}));
		end
		p_tx <= '{en: txen, data: txen ? (rmii ? {2'h0, txd[1:0]} : txd) : 4'h0};
		p_rx <= rmii && line_rx.en ? {1'b1, line_rx.data[1:0]} : 3'h0;
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 0;
		repeat (80) @(posedge clk);
		chip_n <= 1;
		repeat (8) @(posedge clk);
		for (k = 0; k < 8; k++)
		begin
			axi(TBL[k][74], TBL[k][73:66], TBL[k][65:34]);
			if (!TBL[k][74]) cmp("rdata", TBL[k][33:2], rdat);
			cmp("resp", {30'h0, TBL[k][1:0]}, {30'h0, rsp});
		end
		// Pin follows the last mode write one edge after the response
		@(posedge clk);
		cmp1("oe_n", 0, oe_n);
		cmp1("light_100", 0, lout);
		axi(1, 8'h00, 32'h0);
		repeat (3) @(posedge clk);
		cmp1("light_10", 1, lout);
		// Back to 100 Mbps so reserved and idle codes must darken a lit pin
		axi(1, 8'h00, 32'h0000_2000);
		for (k = 2; k < 4; k++)
		begin
			axi(1, 8'h7C, 32'(k << 4));
			repeat (3) @(posedge clk);
			cmp1("light_rsvd", 1, lout);
		end
		axi(1, 8'h7C, 32'h0000_0010);
		repeat (3) @(posedge clk);
		cmp1("light_idle", 1, lout);
		// MII frame then RMII frame; monitor off while the mode crosses
		for (k = 0; k < 2; k++)
		begin
			mon_on <= 0;
			axi(1, 8'h80, 32'(k));
			repeat (4) @(posedge lclk);
			rmii <= k[0];
			mon_on <= 1;
			@(posedge clk);
			go <= !go;
			for (t = 0; t < 200 && lout !== 0; t++) @(posedge clk);
			cmp1("light_on", 0, lout);
			count_flips(40);
			cmp1("blinking", 1, t >= 4);
			for (t = 0; t < 400 && txen === 1; t++) @(posedge clk);
			repeat (50) @(posedge clk);
			count_flips(20);
			cmp("stopped", 0, 32'(t));
			cmp1("light_off", 1, lout);
		end
		// Strap low through a chip reset in mid-run
		mon_on <= 0;
		pull <= 0;
		chip_n <= 0;
		repeat (80) @(posedge clk);
		cmp1("oe_rst", 1, oe_n);
		cmp1("out_rst", 1, lout);
		chip_n <= 1;
		repeat (8) @(posedge clk);
		axi(0, 8'h00, 32'h0);
		cmp("speed_10", 32'h0, rdat);
		axi(0, 8'h10, 32'h0);
		cmp("advert_10", 32'h0000_0060, rdat);
		cmp1("light_10s", 1, lout);
		wrap_up();
	end
endmodule // pmlp_top_bench
